// ### tcc_pkg.sv
// Constants for the timer clock select, prescaler and counter block.
// Assumes an 8-bit register port with one-cycle read latency.
`default_nettype none

package tcc_pkg;

	// Register port geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_COUNT_HIGH     = 8'h01;
	localparam logic [7:0] OFS_COUNT_LOW      = 8'h02;

	// Field positions inside timer_status_control
	localparam int unsigned PS_LSB  = 0;
	localparam int unsigned PS_W    = 3;
	localparam int unsigned CLK_LSB = 3;
	localparam int unsigned CLK_W   = 2;

	// Reset values
	localparam logic [1:0]  RST_CLK_SEL = 2'h0;
	localparam logic [2:0]  RST_PS_SEL  = 3'h0;
	localparam logic [15:0] RST_COUNT   = 16'h0000;

	// Clock source codes
	localparam logic [1:0] SRC_NONE  = 2'h0;
	localparam logic [1:0] SRC_BUS   = 2'h1;
	localparam logic [1:0] SRC_FIXED = 2'h2;
	localparam logic [1:0] SRC_EXT   = 2'h3;

	// External clock may run at most at bus rate divided by this
	localparam int unsigned EXT_MAX_DIV = 4;

	// Counter and prescaler widths
	localparam int unsigned COUNT_W = 16;
	localparam int unsigned PRE_W   = 7;

	// Coherent readout states
	typedef enum logic [2:0] {
		COH_IDLE      = 3'b001,
		COH_WAIT_LOW  = 3'b010,
		COH_WAIT_HIGH = 3'b100
	} tcc_coh_e;

endpackage

`default_nettype wire

// ### tcc_prescaler.sv
// Power-of-two prescaler: passes one of every 2^sel source ticks.
// Assumes i_tick is a one-cycle pulse synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none

module tcc_prescaler
	import tcc_pkg::*;
#(
	parameter int unsigned SEL_W = PS_W,
	parameter int unsigned CNT_W = PRE_W
)
(
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_tick,
	input  wire logic [SEL_W-1:0] i_sel,
	output logic                  o_pulse
);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] mask;

	// Low bits that must all be set for an output pulse
	assign mask = ~({CNT_W{1'b1}} << i_sel);

	// Divide by 1, 2, 4 ... 128
	assign o_pulse = i_tick && ((cnt & mask) == mask);

	////////////////////////////////////////////////////////////////////////
	// Free divider count, advanced only by source ticks
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			cnt <= '0;
		else if (i_tick)
			cnt <= cnt + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// After a pulse the masked count has wrapped to zero
	a_pulse_rate: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_pulse |=> ((cnt & $past(mask)) == '0))
		else $error("prescaler pulse off its divisor");

endmodule

`default_nettype wire

// ### tcc_timer.sv
// Timer clock source select, prescaler and 16-bit counter with
// coherent byte readout behind an 8-bit register port.
// Assumes strobes are one cycle, never together; pins synchronous.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer
	import tcc_pkg::*;
#(
	parameter int unsigned CW = COUNT_W
)
(
	input  wire logic              i_clk,
	input  wire logic              i_rstn,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	input  wire logic              i_fixed_system_clock,
	input  wire logic              i_channel0_pin,
	output logic      [CW-1:0]     o_count,
	output logic                   o_count_tick
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [CLK_W-1:0] clock_source_select;
	logic [PS_W-1:0]  prescale_select;
	logic [CW-1:0]    count;
	logic [CW-1:0]    hold;
	logic             pin_last;
	logic             pin_rise;
	logic             src_tick;
	logic             pre_pulse;
	logic             sel_ctrl;
	logic             sel_high;
	logic             sel_low;
	logic             wr_ctrl;
	logic             wr_count;
	logic             rd_high;
	logic             rd_low;
	logic             rearm;
	tcc_coh_e         coh;
	tcc_coh_e         next_coh;
	logic [DATA_W-1:0] next_rdata;
	logic [PRE_W:0]   gap;
	logic             gap_valid;

	////////////////////////////////////////////////////////////////////////
	// Address decode
	assign sel_ctrl = (i_addr == OFS_STATUS_CONTROL);
	assign sel_high = (i_addr == OFS_COUNT_HIGH);
	assign sel_low  = (i_addr == OFS_COUNT_LOW);
	assign wr_ctrl  = i_wr && sel_ctrl;
	assign wr_count = i_wr && (sel_high || sel_low);
	assign rd_high  = i_rd && sel_high;
	assign rd_low   = i_rd && sel_low;

	// Any of these writes abandons a half-finished read
	assign rearm = wr_ctrl || wr_count;

	////////////////////////////////////////////////////////////////////////
	// Control register: source and prescale fields
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			clock_source_select <= RST_CLK_SEL;
			prescale_select     <= RST_PS_SEL;
		end
		else if (wr_ctrl)
		begin
			clock_source_select <= i_wdata[CLK_LSB +: CLK_W];
			prescale_select     <= i_wdata[PS_LSB +: PS_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel 0 pin edge finder; the pin is already synchronous.
	// Each high and low phase needs only one bus cycle to be seen, yet
	// the external rate is held to a quarter of the bus rate.
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			pin_last <= 1'b0;
		else
			pin_last <= i_channel0_pin;
	end

	assign pin_rise = i_channel0_pin && !pin_last;

	////////////////////////////////////////////////////////////////////////
	// Clock source multiplexer
	always_comb
	begin
		case (clock_source_select)
			SRC_NONE:  src_tick = 1'b0;
			SRC_BUS:   src_tick = 1'b1;
			SRC_FIXED: src_tick = i_fixed_system_clock;
			SRC_EXT:   src_tick = pin_rise;
			default:   src_tick = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Prescaler
	tcc_prescaler #(
		.SEL_W (PS_W),
		.CNT_W (PRE_W)
	) u_prescaler (
		.i_clk   (i_clk),
		.i_rstn  (i_rstn),
		.i_tick  (src_tick),
		.i_sel   (prescale_select),
		.o_pulse (pre_pulse)
	);

	////////////////////////////////////////////////////////////////////////
	// Main counter
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			count <= RST_COUNT[CW-1:0];
		else if (pre_pulse)
			count <= count + 1'b1;
	end

	assign o_count      = count;
	assign o_count_tick = pre_pulse;

	////////////////////////////////////////////////////////////////////////
	// Cycles since the last prescaler pulse, for the spacing check;
	// a control write restarts it because the first pulse may be early.
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn || wr_ctrl)
		begin
			gap       <= '0;
			gap_valid <= 1'b0;
		end
		else if (pre_pulse)
		begin
			gap       <= '0;
			gap_valid <= 1'b1;
		end
		else if (gap != '1)
			gap <= gap + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Coherent readout state
	always_comb
	begin
		next_coh = coh;
		case (coh)
			COH_IDLE:
			begin
				if (rd_high)
					next_coh = COH_WAIT_LOW;
				else if (rd_low)
					next_coh = COH_WAIT_HIGH;
			end
			COH_WAIT_LOW:
			begin
				if (rd_low)
					next_coh = COH_IDLE;
			end
			COH_WAIT_HIGH:
			begin
				if (rd_high)
					next_coh = COH_IDLE;
			end
			default:
				next_coh = COH_IDLE;
		endcase
		if (rearm)
			next_coh = COH_IDLE;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			coh <= COH_IDLE;
		else
			coh <= next_coh;
	end

	////////////////////////////////////////////////////////////////////////
	// Buffer both bytes on the first read of a pair
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			hold <= RST_COUNT[CW-1:0];
		else if ((coh == COH_IDLE) && (rd_high || rd_low))
			hold <= count;
	end

	////////////////////////////////////////////////////////////////////////
	// Read data mux; unmapped offsets read zero
	always_comb
	begin
		next_rdata = '0;
		if (sel_ctrl)
		begin
			next_rdata[CLK_LSB +: CLK_W] = clock_source_select;
			next_rdata[PS_LSB +: PS_W]   = prescale_select;
		end
		else if (sel_high)
			next_rdata = (coh == COH_IDLE) ? count[15:8] : hold[15:8];
		else if (sel_low)
			next_rdata = (coh == COH_IDLE) ? count[7:0] : hold[7:0];
	end

	// Read data stand for exactly the cycle after the strobe
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			o_rdata <= '0;
		else if (i_rd)
			o_rdata <= next_rdata;
		else
			o_rdata <= '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on source selection

	a_disabled_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(clock_source_select == SRC_NONE) |=> $stable(count))
		else $error("counter moved while disabled");

	a_bus_source: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(clock_source_select == SRC_BUS) |-> src_tick)
		else $error("bus source missed a tick");

	a_fixed_source: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(clock_source_select == SRC_FIXED) |-> (src_tick == i_fixed_system_clock))
		else $error("fixed source not followed");

	a_ext_source: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(clock_source_select == SRC_EXT) |-> (src_tick == pin_rise))
		else $error("external source not followed");

	a_div_one: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(clock_source_select == SRC_BUS && prescale_select == 3'h0)
		|=> (count == $past(count) + 16'h0001))
		else $error("divide by one did not step every cycle");

	////////////////////////////////////////////////////////////////////////
	// Checks on counter and readout

	a_count_step: assert property (@(posedge i_clk) disable iff (!i_rstn)
		pre_pulse |=> (count == $past(count) + 16'h0001))
		else $error("counter did not step on pulse");

	a_reset_zero: assert property (@(posedge i_clk)
		!i_rstn |=> (count == 16'h0000 && coh == COH_IDLE))
		else $error("reset did not clear counter");

	a_first_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(rd_high && coh == COH_IDLE)
		|=> (o_rdata == $past(count[15:8]) && coh == COH_WAIT_LOW && hold == $past(count)))
		else $error("first high read wrong");

	a_pair_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(rd_low && coh == COH_WAIT_LOW)
		|=> (o_rdata == $past(hold[7:0]) && coh == COH_IDLE))
		else $error("buffered low byte wrong");

	a_rearm_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
		rearm |=> (coh == COH_IDLE))
		else $error("write did not rearm readout");

	////////////////////////////////////////////////////////////////////////
	// Checks on pairing, read data and pulse spacing

	a_first_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(rd_low && coh == COH_IDLE)
		|=> (o_rdata == $past(count[7:0]) && coh == COH_WAIT_HIGH && hold == $past(count)))
		else $error("first low read wrong");

	a_pair_high: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(rd_high && coh == COH_WAIT_HIGH)
		|=> (o_rdata == $past(hold[15:8]) && coh == COH_IDLE))
		else $error("buffered high byte wrong");

	a_high_reread: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(rd_high && coh == COH_WAIT_LOW)
		|=> (o_rdata == $past(hold[15:8]) && coh == COH_WAIT_LOW))
		else $error("high reread left the buffer");

	a_low_reread: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(rd_low && coh == COH_WAIT_HIGH)
		|=> (o_rdata == $past(hold[7:0]) && coh == COH_WAIT_HIGH))
		else $error("low reread left the buffer");

	a_hold_steady: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(coh != COH_IDLE) |=> $stable(hold))
		else $error("buffer changed during a pair");

	a_rdata_one: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!i_rd |=> (o_rdata == 8'h00))
		else $error("read data outlived its cycle");

	a_no_pulse_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!pre_pulse |=> $stable(count))
		else $error("counter moved without a pulse");

	a_count_readonly: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(wr_count && !pre_pulse) |=> $stable(count))
		else $error("counter byte write changed the count");

	a_disabled_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(clock_source_select == SRC_NONE) |-> !pre_pulse)
		else $error("prescaler pulsed while disabled");

	a_ext_level: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(clock_source_select == SRC_EXT && pin_last) |-> !src_tick)
		else $error("external source ticked on a level");

	a_reset_rearm: assert property (@(posedge i_clk)
		!i_rstn |=> (coh == COH_IDLE && hold == 16'h0000 && o_rdata == 8'h00))
		else $error("reset left the readout armed");

	// Steady bus source: pulses exactly one divisor apart
	a_bus_spacing: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(clock_source_select == SRC_BUS && pre_pulse && gap_valid)
		|-> ((gap + 1'b1) == ({{PRE_W{1'b0}}, 1'b1} << prescale_select)))
		else $error("bus source pulse spacing wrong");

endmodule

`default_nettype wire

// ### tcc_timer_tb.sv
// Self-checking bench for the timer clock select, prescaler and counter.
// Assumes tcc_timer with its register port and one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tcc_timer_tb;
	import tcc_pkg::*;

	logic               i_clk = 1'b0;
	logic               i_rstn = 1'b0;
	logic [ADDR_W-1:0]  i_addr = 8'h00;
	logic [DATA_W-1:0]  i_wdata = 8'h00;
	logic               i_wr = 1'b0;
	logic               i_rd = 1'b0;
	logic               fix_tick = 1'b0;
	logic               ext_pin = 1'b0;
	logic [DATA_W-1:0]  o_rdata;
	logic [COUNT_W-1:0] o_count;
	logic               o_count_tick;
	logic [15:0]        exp_cnt = 16'h0000;
	logic [15:0]        c0;
	int                 mismatches = 0;
	int                 samples_checked = 0;
	int                 cycles = 0;

	tcc_timer tcc_timer_inst (
		.i_clk                (i_clk),
		.i_rstn               (i_rstn),
		.i_addr               (i_addr),
		.i_wdata              (i_wdata),
		.i_wr                 (i_wr),
		.i_rd                 (i_rd),
		.o_rdata              (o_rdata),
		.i_fixed_system_clock (fix_tick),
		.i_channel0_pin       (ext_pin),
		.o_count              (o_count),
		.o_count_tick         (o_count_tick)
	);

	// Clock and hang guard
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		if (got !== exp)
			mismatches++;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// Read and compare the byte in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk({8'h00, o_rdata}, {8'h00, e});
	endtask

	task automatic fpulse(input int n, input bit en);
		repeat (n)
		begin
			@(posedge i_clk) fix_tick <= 1'b1;
			@(posedge i_clk) fix_tick <= 1'b0;
			exp_cnt += 16'(en);
		end
		#1;
	endtask

	// Pin high two cycles, low two cycles per rising edge
	task automatic epulse(input int n, input bit en);
		repeat (n)
		begin
			@(posedge i_clk) ext_pin <= 1'b1;
			@(posedge i_clk);
			@(posedge i_clk) ext_pin <= 1'b0;
			@(posedge i_clk);
			exp_cnt += 16'(en);
		end
		repeat (3) @(posedge i_clk);
		#1;
	endtask

	task automatic do_reset();
		@(posedge i_clk) i_rstn <= 1'b0;
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		exp_cnt = 16'h0000;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		do_reset();
		chk(o_count, 16'h0000);
		rd(OFS_STATUS_CONTROL, 8'h00);
		rd(8'h07, 8'h00);
		rd(OFS_COUNT_HIGH, 8'h00);
		rd(OFS_COUNT_LOW, 8'h00);
		#10 chk({8'h00, o_rdata}, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_sources();
		wr(OFS_STATUS_CONTROL, {3'h0, SRC_FIXED, 3'h0});
		@(posedge i_clk) fix_tick <= 1'b1;
		#1 chk({15'h0, o_count_tick}, 16'h0001);
		@(posedge i_clk) fix_tick <= 1'b0;
		#1 chk({15'h0, o_count_tick}, 16'h0000);
		exp_cnt += 16'h0001;
		fpulse(4, 1);
		epulse(2, 0);
		chk(o_count, exp_cnt);
		wr(OFS_STATUS_CONTROL, {3'h0, SRC_EXT, 3'h0});
		epulse(4, 1);
		fpulse(2, 0);
		chk(o_count, exp_cnt);
		wr(OFS_STATUS_CONTROL, {3'h0, SRC_NONE, 3'h0});
		fpulse(3, 0);
		epulse(3, 0);
		repeat (20) @(posedge i_clk);
		#1 chk(o_count, exp_cnt);
		$display("test sources done");
	endtask

	task automatic t_coherent();
		do_reset();
		wr(OFS_STATUS_CONTROL, {3'h0, SRC_FIXED, 3'h0});
		fpulse(300, 1);
		rd(OFS_COUNT_HIGH, 8'h01);
		fpulse(20, 1);
		rd(OFS_COUNT_LOW, 8'h2c);
		rd(OFS_COUNT_LOW, 8'h40);
		fpulse(3, 1);
		rd(OFS_COUNT_LOW, 8'h40);
		fpulse(250, 1);
		rd(OFS_COUNT_LOW, 8'h40);
		rd(OFS_COUNT_HIGH, 8'h01);
		rd(OFS_COUNT_HIGH, 8'h02);
		fpulse(5, 1);
		rd(OFS_COUNT_HIGH, 8'h02);
		wr(OFS_COUNT_LOW, 8'h5a);
		chk(o_count, exp_cnt);
		rd(OFS_COUNT_LOW, 8'h42);
		rd(OFS_COUNT_LOW, 8'h42);
		fpulse(2, 1);
		wr(OFS_STATUS_CONTROL, {3'h0, SRC_FIXED, 3'h0});
		rd(OFS_COUNT_LOW, 8'h44);
		rd(OFS_COUNT_HIGH, 8'h02);
		$display("test coherent done");
	endtask

	task automatic t_prescale();
		for (int k = 0; k < 8; k++)
		begin
			wr(OFS_STATUS_CONTROL, {3'h0, SRC_BUS, 3'(k)});
			rd(OFS_STATUS_CONTROL, {3'h0, SRC_BUS, 3'(k)});
			repeat (2) @(posedge i_clk);
			#1 c0 = o_count;
			repeat (2 << k) @(posedge i_clk);
			#1 chk(o_count - c0, 16'h0002);
		end
		do_reset();
		chk(o_count, 16'h0000);
		rd(OFS_STATUS_CONTROL, 8'h00);
		$display("test prescale done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		t_reset();
		t_sources();
		t_coherent();
		t_prescale();
		report_and_stop();
	end

endmodule

`default_nettype wire
